//--- common/rrs_pkg.sv
package rrs_pkg;
    typedef enum logic [1:0] {
        RRS_POR_HOLD = 2'b00,
        RRS_RUN = 2'b01
    } rrs_state_t;
endpackage : rrs_pkg

//--- common/rrs_regs.svh
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH

// Clock rate in kHz (25 MHz)
`define RRS_CLK_KHZ 25000
// Longest internal power-on reset hold, in ms
`define RRS_POR_MAX_MS 110
// Longest hold in cycles, exact product of ms and kHz
`define RRS_POR_MAX_CYC (`RRS_POR_MAX_MS * `RRS_CLK_KHZ)
// Host wait before link access, in ms
`define RRS_HOST_WAIT_MS 150
`define RRS_HOST_WAIT_CYC (`RRS_HOST_WAIT_MS * `RRS_CLK_KHZ)
// Least gap between pin toggles after both low, in ms
`define RRS_OFF_GAP_MS 10
`define RRS_OFF_GAP_CYC (`RRS_OFF_GAP_MS * `RRS_CLK_KHZ)
// Counter width
`define RRS_CNT_W 32

`endif

//--- design/rrs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rrs_regs.svh"
module rrs_sequencer #(
    parameter logic [`RRS_CNT_W-1:0] POR_HOLD_CYC = `RRS_CNT_W'(`RRS_POR_MAX_CYC)
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wlan_power_on_pin,
    input wire logic bt_power_on_pin,
    output logic regulator_enable,
    output logic wlan_reset_n,
    output logic bt_reset_n,
    output logic por_active
);
    logic wlan_on;
    logic bt_on;
    rrs_pkg::rrs_state_t state_r;
    rrs_pkg::rrs_state_t state_nxt;
    logic [`RRS_CNT_W-1:0] cnt_r;
    logic [`RRS_CNT_W-1:0] cnt_nxt;
    logic reg_en_r;
    logic reg_en_nxt;
    logic wlan_rst_n_r;
    logic wlan_rst_n_nxt;
    logic bt_rst_n_r;
    logic bt_rst_n_nxt;
    logic por_r;
    logic por_nxt;

    rrs_sync u_sync_wlan (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_async(wlan_power_on_pin),
        .pin_sync(wlan_on)
    );

    rrs_sync u_sync_bt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_async(bt_power_on_pin),
        .pin_sync(bt_on)
    );

    // Hold state leaves once the counter reaches the hold length minus one
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rrs_pkg::RRS_POR_HOLD: begin
                if (cnt_r >= POR_HOLD_CYC - `RRS_CNT_W'(1)) begin
                    state_nxt = rrs_pkg::RRS_RUN;
                end
            end
            rrs_pkg::RRS_RUN: begin
                state_nxt = rrs_pkg::RRS_RUN;
            end
            default: begin
                state_nxt = rrs_pkg::RRS_POR_HOLD;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= rrs_pkg::RRS_POR_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Power-on reset hold counter, stops at its last value
    always_comb begin
        cnt_nxt = cnt_r;
        unique case (state_r)
            rrs_pkg::RRS_POR_HOLD: begin
                if (cnt_r < POR_HOLD_CYC - `RRS_CNT_W'(1)) begin
                    cnt_nxt = cnt_r + `RRS_CNT_W'(1);
                end
            end
            rrs_pkg::RRS_RUN: begin
                cnt_nxt = cnt_r;
            end
            default: begin
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Regulators on while either pin is high
    always_comb begin
        reg_en_nxt = 1'b0;
        unique case ({wlan_on, bt_on})
            2'h0: begin
                reg_en_nxt = 1'b0;
            end
            2'h1: begin
                reg_en_nxt = 1'b1;
            end
            2'h2: begin
                reg_en_nxt = 1'b1;
            end
            2'h3: begin
                reg_en_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_en_r <= 1'b0;
        end else begin
            reg_en_r <= reg_en_nxt;
        end
    end

    // Internal power-on reset flag follows the hold state
    always_comb begin
        por_nxt = 1'b1;
        if (state_nxt == rrs_pkg::RRS_RUN) begin
            por_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            por_r <= 1'b1;
        end else begin
            por_r <= por_nxt;
        end
    end

    // WLAN section released only by its own pin after power-on reset
    always_comb begin
        wlan_rst_n_nxt = 1'b0;
        if (por_nxt) begin
            wlan_rst_n_nxt = 1'b0;
        end else begin
            unique case ({wlan_on, bt_on})
                2'h0: begin
                    wlan_rst_n_nxt = 1'b0;
                end
                2'h1: begin
                    wlan_rst_n_nxt = 1'b0;
                end
                2'h2: begin
                    wlan_rst_n_nxt = 1'b1;
                end
                2'h3: begin
                    wlan_rst_n_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wlan_rst_n_r <= 1'b0;
        end else begin
            wlan_rst_n_r <= wlan_rst_n_nxt;
        end
    end

    // BT section released only by its own pin after power-on reset
    always_comb begin
        bt_rst_n_nxt = 1'b0;
        if (por_nxt) begin
            bt_rst_n_nxt = 1'b0;
        end else begin
            unique case ({wlan_on, bt_on})
                2'h0: begin
                    bt_rst_n_nxt = 1'b0;
                end
                2'h1: begin
                    bt_rst_n_nxt = 1'b1;
                end
                2'h2: begin
                    bt_rst_n_nxt = 1'b0;
                end
                2'h3: begin
                    bt_rst_n_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bt_rst_n_r <= 1'b0;
        end else begin
            bt_rst_n_r <= bt_rst_n_nxt;
        end
    end

    assign regulator_enable = reg_en_r;
    assign wlan_reset_n = wlan_rst_n_r;
    assign bt_reset_n = bt_rst_n_r;
    assign por_active = por_r;
endmodule : rrs_sequencer
`default_nettype wire

//--- design/rrs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rrs_sync (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic pin_async,
    output logic pin_sync
);
    logic stage1_r;
    logic stage2_r;
    logic stage1_nxt;
    logic stage2_nxt;

    always_comb begin
        stage1_nxt = pin_async;
        stage2_nxt = stage1_r;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign pin_sync = stage2_r;
endmodule : rrs_sync
`default_nettype wire

//--- testbench/rrs_host.sv
`timescale 1ns/1ps
`default_nettype none
module rrs_host (
    input wire logic sys_clk,
    output logic [1:0] pins
);
    logic [2:0] gap_r = 3'h0;
    initial pins = 2'h0;
    // No link access is issued, so the settle wait holds
    always @(posedge sys_clk) begin
        gap_r <= (pins == 2'h0 && gap_r != 3'h7) ? gap_r + 3'h1 : 3'h0;
        if (pins != 2'h0 || gap_r == 3'h7) pins <= 2'($urandom_range(3));
    end
endmodule : rrs_host
`default_nettype wire

//--- testbench/rrs_props.sv
`timescale 1ns/1ps
`default_nettype none
module rrs_props #(parameter logic [31:0] POR_HOLD_CYC = 32'h14) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wlan_power_on_pin,
    input wire logic bt_power_on_pin,
    input wire logic regulator_enable,
    input wire logic wlan_reset_n,
    input wire logic bt_reset_n,
    input wire logic por_active
);
    logic [31:0] cnt_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) cnt_r <= 32'h0;
        else if (por_active) cnt_r <= cnt_r + 32'h1;
    end
    chk_reg_follow: assert property ($past(reset_n, 3) |->
        regulator_enable == $past(wlan_power_on_pin | bt_power_on_pin, 3)) else $error("reg");
    chk_wlan_follow: assert property ($past(reset_n, 3) && !$past(por_active) |->
        wlan_reset_n == $past(wlan_power_on_pin, 3)) else $error("wlan");
    chk_bt_hold: assert property (!$past(bt_power_on_pin, 3) |-> !bt_reset_n)
        else $error("bt");
    chk_por_time: assert property (por_active |-> cnt_r <= POR_HOLD_CYC + 32'h1)
        else $error("por long");
    chk_por_hold: assert property (por_active |-> !wlan_reset_n && !bt_reset_n)
        else $error("por leak");
    chk_por_stays_off: assert property (!por_active |=> !por_active)
        else $error("por back");
endmodule : rrs_props
bind rrs_sequencer rrs_props #(.POR_HOLD_CYC(POR_HOLD_CYC)) rrs_props_inst (.sys_clk, .reset_n,
    .wlan_power_on_pin, .bt_power_on_pin, .regulator_enable, .wlan_reset_n, .bt_reset_n,
    .por_active);
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module testbench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] pins;
    logic [1:0] e;
    logic [1:0] q[$];
    logic reg_en, wl_rn, bt_rn, por;
    logic pp = 1'b1;
    int n_errors = 0;
    int checks_done = 0;
    int por_cnt = 0;
    rrs_host rrs_host_inst (.sys_clk, .pins);
    rrs_sequencer #(.POR_HOLD_CYC(32'h14)) rrs_sequencer_inst (.sys_clk, .reset_n,
        .wlan_power_on_pin(pins[1]), .bt_power_on_pin(pins[0]), .regulator_enable(reg_en),
        .wlan_reset_n(wl_rn), .bt_reset_n(bt_rn), .por_active(por));
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (!reset_n) q.delete(); else q.push_back(pins);
    always @(posedge sys_clk) por_cnt <= reset_n ? por_cnt + 1 : 0;
    always @(negedge sys_clk) begin
        if (reset_n) `CHK(por, por_cnt < 32'h14)
        if (reset_n && q.size() > 2) begin
            e = q.pop_front();
            `CHK(reg_en, |e)
            if (por === 1'b1) `CHK({wl_rn, bt_rn}, 2'h0)
            else if (!pp) `CHK({wl_rn, bt_rn}, e)
        end
        pp = por;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        void'($urandom(32'h87648b3e));
        for (int i = 0; i < 824; i++) begin
            @(posedge sys_clk);
            reset_n <= i > 10 && (i < 411 || i > 422);
        end
        end_sim();
    end
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
